// ---- baler_pkg.sv ----
// Purpose: Shared constants and types for the baling press cycle controller
// Assumes: pclk at 100 MHz, APB register access with 32-bit data
// Notes:   Cycle counts are derived from times given in milliseconds
package baler_pkg;
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
	localparam int unsigned HOLD_MS       = 500;
	localparam int unsigned START_MS      = 4000;
	localparam int unsigned IDLE_MS       = 16000;
	localparam int unsigned SETTLE_MS     = 500;
	localparam int unsigned STROKE_MS     = 15000;
	localparam int unsigned BLINK_MS      = 250;
	localparam int unsigned CYC_HOLD      = HOLD_MS * CYC_PER_MS;
	localparam int unsigned CYC_START     = START_MS * CYC_PER_MS;
	localparam int unsigned CYC_IDLE      = IDLE_MS * CYC_PER_MS;
	localparam int unsigned CYC_SETTLE    = SETTLE_MS * CYC_PER_MS;
	localparam int unsigned CYC_STROKE    = STROKE_MS * CYC_PER_MS;
	localparam int unsigned CYC_BLINK     = BLINK_MS * CYC_PER_MS;
	localparam logic [7:0]  AUTO_LIMIT    = 8'h7F;
	localparam logic [1:0]  OVR_FINAL     = 2'h3;
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_STATUS   = 8'h04;
	localparam logic [7:0]  ADDR_COUNT    = 8'h08;
	localparam logic [7:0]  ADDR_DISPLAY  = 8'h0C;
	localparam int unsigned CTRL_GUARD    = 0;
	localparam int unsigned CTRL_TEMP     = 1;
	localparam logic [1:0]  CTRL_RESET    = 2'h0;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_SPIN   = 3'h1,
		ST_DOWN   = 3'h3,
		ST_SETTLE = 3'h2,
		ST_UP     = 3'h6,
		ST_EJECT  = 3'h7,
		ST_HALT   = 3'h4
	} state_t;

	typedef enum logic [2:0] {
		DISP_COUNT                = 3'h0,
		override_count_one        = 3'h1,
		override_count_two        = 3'h2,
		override_count_final      = 3'h3,
		DISP_PS_OPEN              = 3'h4,
		DISP_PS_JAM               = 3'h5,
		excess_cycling_code       = 3'h6,
		DISP_HOT_OR_GUARD         = 3'h7
	} disp_code_t;

	typedef struct packed {
		logic       door_shut;
		logic       hopper;
		logic       full_bale;
		logic       pressure;
		logic       oil_hot;
		logic [1:0] guard_closed;
	} sensors_t;

	typedef struct packed {
		logic cycle;
		logic retract;
		logic eject;
	} keys_t;

	typedef struct packed {
		logic motor;
		logic up;
		logic down;
	} drive_t;

	typedef struct packed {
		logic up;
		logic down;
		logic active;
		logic full;
		logic beeper;
		logic door_open;
	} leds_t;

	typedef struct packed {
		disp_code_t  code;
		logic        guard;
		logic [15:0] value;
	} disp_t;

	typedef struct packed {
		state_t      st;
		logic [31:0] timer;
		logic [31:0] idle;
		logic [31:0] blink;
		logic [31:0] hold_cyc;
		logic [31:0] hold_ret;
		logic        blink_on;
		logic        motor;
		logic        dir_up;
		logic        ret_down;
		logic        seen_open;
		logic        at_bottom;
		logic        auto_mode;
		logic        full_pend;
		logic        full;
		logic        excess;
		logic        ps_open;
		logic        ps_jam;
		logic [1:0]  ovr;
		logic [7:0]  auto_cnt;
		logic [15:0] bales;
		logic [1:0]  ctrl;
		drive_t      drv;
		leds_t       leds;
		disp_t       disp;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} ctl_state_t;
endpackage : baler_pkg

// ---- baler_press_cycle_controller.sv ----
// Purpose: Press sequencing, motor control and safety interlocks of a baler
// Assumes: Sensor and key inputs already synchronous to pclk, active high
// Notes:   Long times are parameters so a simulation can shorten them
`timescale 1ns/1ps
module baler_press_cycle_controller
	import baler_pkg::*;
#(
	parameter logic [31:0] HOLD_CYC   = CYC_HOLD,
	parameter logic [31:0] START_CYC  = CYC_START,
	parameter logic [31:0] IDLE_CYC   = CYC_IDLE,
	parameter logic [31:0] SETTLE_CYC = CYC_SETTLE,
	parameter logic [31:0] STROKE_CYC = CYC_STROKE,
	parameter logic [31:0] BLINK_CYC  = CYC_BLINK
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire sensors_t    sens,
	input  wire keys_t       keys,
	output drive_t           drive,
	output leds_t            leds,
	output disp_t            display
);
	ctl_state_t r;
	ctl_state_t next_r;

	function automatic logic done(input logic [31:0] t, input logic [31:0] lim);
		done = (t >= lim - 32'h1);
	endfunction : done

	function automatic logic [31:0] reg_read(input ctl_state_t s, input logic [7:0] a);
		case (a)
			ADDR_CTRL:    reg_read = {30'h0, s.ctrl};
			ADDR_STATUS:  reg_read = {16'h0, s.auto_cnt, s.ps_jam, s.ps_open, s.excess,
			                          s.full, s.auto_mode, s.st};
			ADDR_COUNT:   reg_read = {14'h0, s.ovr, s.bales};
			ADDR_DISPLAY: reg_read = {12'h0, s.disp.guard, s.disp.code, s.disp.value};
			default:      reg_read = 32'h0;
		endcase
	endfunction : reg_read

	always_comb
	begin
		logic door_bad;
		logic guard_bad;
		logic cyc_go;
		logic ret_go;
		logic want;
		logic want_up;
		logic final_ovr;
		door_bad  = 1'b0;
		guard_bad = 1'b0;
		cyc_go    = 1'b0;
		ret_go    = 1'b0;
		want      = 1'b0;
		want_up   = 1'b0;
		final_ovr = 1'b0;
		next_r    = r;
		next_r.pready  = 1'b0;
		next_r.pslverr = 1'b0;

		// Register access: answer in the first access cycle
		if (psel && !penable)
		begin
			next_r.pready  = 1'b1;
			next_r.prdata  = reg_read(r, paddr);
			next_r.pslverr = !(paddr == ADDR_CTRL || paddr == ADDR_STATUS ||
			                   paddr == ADDR_COUNT || paddr == ADDR_DISPLAY);
		end
		if (psel && penable && r.pready && pwrite && paddr == ADDR_CTRL)
			next_r.ctrl = pwdata[1:0];

		door_bad  = !sens.door_shut;
		guard_bad = r.ctrl[CTRL_GUARD] && (sens.guard_closed != 2'b11);
		final_ovr = r.full && (r.ovr == OVR_FINAL);

		// Key filters emit one pulse when a hold reaches half a second
		if (keys.cycle && !door_bad && !guard_bad)
			next_r.hold_cyc = done(r.hold_cyc, HOLD_CYC) ? r.hold_cyc : r.hold_cyc + 32'h1;
		else
			next_r.hold_cyc = 32'h0;
		if (keys.retract && !door_bad && !guard_bad)
			next_r.hold_ret = done(r.hold_ret, HOLD_CYC) ? r.hold_ret : r.hold_ret + 32'h1;
		else
			next_r.hold_ret = 32'h0;
		cyc_go = keys.cycle && !door_bad && !guard_bad && (r.hold_cyc == HOLD_CYC - 32'h2);
		ret_go = keys.retract && !door_bad && !guard_bad && (r.hold_ret == HOLD_CYC - 32'h2);

		next_r.blink = done(r.blink, BLINK_CYC) ? 32'h0 : r.blink + 32'h1;
		if (done(r.blink, BLINK_CYC))
			next_r.blink_on = !r.blink_on;
		next_r.timer = r.timer + 32'h1;

		case (r.st)
			ST_IDLE:
			begin
				if (r.motor)
				begin
					next_r.idle = r.idle + 32'h1;
					if (done(r.idle, IDLE_CYC))
						next_r.motor = 1'b0;
				end
				if (ret_go)
				begin
					want           = 1'b1;
					want_up        = 1'b1;
					next_r.ret_down  = 1'b0;
					next_r.auto_mode = 1'b0;
				end
				else if (cyc_go && !final_ovr)
				begin
					if (r.full)
						next_r.ovr = r.ovr + 2'h1;
					next_r.auto_mode = 1'b1;
					next_r.excess    = 1'b0;
					next_r.auto_cnt  = 8'h0;
					want             = 1'b1;
					want_up          = r.at_bottom;
					next_r.ret_down  = r.at_bottom;
				end
				else if (r.auto_mode && sens.hopper && r.at_bottom && !r.full && !door_bad)
				begin
					if (r.auto_cnt == AUTO_LIMIT)
					begin
						next_r.excess    = 1'b1;
						next_r.auto_mode = 1'b0;
					end
					else
					begin
						next_r.auto_cnt = r.auto_cnt + 8'h1;
						want            = 1'b1;
						want_up         = 1'b1;
						next_r.ret_down = 1'b1;
					end
				end
				else if (keys.eject && door_bad)
				begin
					next_r.st    = ST_EJECT;
					next_r.timer = 32'h0;
				end
				if (want)
				begin
					next_r.dir_up    = want_up;
					next_r.idle      = 32'h0;
					next_r.seen_open = 1'b0;
					next_r.timer     = 32'h0;
					next_r.motor     = 1'b1;
					// A cold motor spins up unloaded before any stroke
					next_r.st = r.motor ? (want_up ? ST_UP : ST_DOWN) : ST_SPIN;
				end
			end
			ST_SPIN:
			begin
				if (done(r.timer, START_CYC))
				begin
					next_r.st    = r.dir_up ? ST_UP : ST_DOWN;
					next_r.timer = 32'h0;
				end
			end
			ST_DOWN, ST_UP:
			begin
				if (sens.full_bale)
					next_r.full_pend = 1'b1;
				if (!sens.pressure)
					next_r.seen_open = 1'b1;
				if (r.seen_open && sens.pressure)
				begin
					next_r.st    = ST_SETTLE;
					next_r.timer = 32'h0;
				end
				else if (done(r.timer, STROKE_CYC))
				begin
					next_r.ps_open   = r.seen_open;
					next_r.ps_jam    = !r.seen_open;
					next_r.auto_mode = 1'b0;
					next_r.motor     = 1'b0;
					next_r.st        = ST_HALT;
				end
			end
			ST_SETTLE:
			begin
				if (done(r.timer, SETTLE_CYC))
				begin
					next_r.at_bottom = !r.dir_up;
					next_r.timer     = 32'h0;
					next_r.idle      = 32'h0;
					next_r.st        = ST_IDLE;
					if (r.full_pend)
						next_r.full = 1'b1;
					if (r.dir_up && r.ret_down && !final_ovr)
					begin
						next_r.dir_up    = 1'b0;
						next_r.ret_down  = 1'b0;
						next_r.seen_open = 1'b0;
						next_r.st        = ST_DOWN;
					end
				end
			end
			ST_EJECT:
			begin
				next_r.motor = 1'b1;
				if (!keys.eject || !door_bad)
				begin
					next_r.motor     = 1'b0;
					next_r.bales     = r.bales + 16'h1;
					next_r.ovr       = 2'h0;
					next_r.full      = 1'b0;
					next_r.full_pend = 1'b0;
					next_r.st        = ST_IDLE;
				end
			end
			ST_HALT:
			begin
				next_r.motor = 1'b0;
				if (cyc_go || ret_go)
				begin
					next_r.ps_open = 1'b0;
					next_r.ps_jam  = 1'b0;
					next_r.st      = ST_IDLE;
				end
			end
			default:
				next_r.st = ST_IDLE;
		endcase

		// Interlocks override whatever the sequencer chose, except that an open door leaves eject running
		if (door_bad)
		begin
			next_r.auto_cnt = 8'h0;
			if (next_r.st != ST_EJECT)
			begin
				next_r.motor = 1'b0;
				if (next_r.st != ST_HALT)
					next_r.st = ST_IDLE;
			end
		end
		if (guard_bad)
		begin
			next_r.motor = 1'b0;
			if (next_r.st != ST_HALT)
				next_r.st = ST_IDLE;
		end
		if (r.ctrl[CTRL_TEMP] && sens.oil_hot)
			next_r.auto_mode = 1'b0;

		next_r.drv.motor = next_r.motor;
		next_r.drv.up    = (next_r.st == ST_UP) || (next_r.st == ST_SETTLE && next_r.dir_up);
		next_r.drv.down  = (next_r.st == ST_DOWN) || (next_r.st == ST_SETTLE && !next_r.dir_up);
		// Direction LED stays lit through spin-up and settle, then drops
		next_r.leds.up   = (next_r.st == ST_EJECT) || (next_r.dir_up &&
		                   (next_r.st == ST_SPIN || next_r.drv.up));
		next_r.leds.down = (next_r.st == ST_EJECT) || (!next_r.dir_up &&
		                   (next_r.st == ST_SPIN || next_r.drv.down));
		next_r.leds.active    = next_r.auto_mode && next_r.blink_on;
		next_r.leds.full      = next_r.full;
		next_r.leds.beeper    = next_r.full;
		next_r.leds.door_open = door_bad;

		next_r.disp.guard = guard_bad;
		next_r.disp.value = next_r.bales;
		if (guard_bad || (r.ctrl[CTRL_TEMP] && sens.oil_hot))
			next_r.disp.code = DISP_HOT_OR_GUARD;
		else if (next_r.ps_open)
			next_r.disp.code = DISP_PS_OPEN;
		else if (next_r.ps_jam)
			next_r.disp.code = DISP_PS_JAM;
		else if (next_r.excess)
			next_r.disp.code = excess_cycling_code;
		else if (next_r.full && next_r.ovr != 2'h0)
			next_r.disp.code = disp_code_t'({1'b0, next_r.ovr});
		else
			next_r.disp.code = DISP_COUNT;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r      <= '0;
			r.st   <= ST_IDLE;
			r.ctrl <= CTRL_RESET;
		end
		else
			r <= next_r;
	end

	assign prdata  = r.prdata;
	assign pready  = r.pready;
	assign pslverr = r.pslverr;
	assign drive   = r.drv;
	assign leds    = r.leds;
	assign display = r.disp;
endmodule : baler_press_cycle_controller

// ---- baler_press_cycle_controller_assertions.sv ----
// Purpose: Port checks of the press controller
// Assumes: One clock, bound to the controller
// Notes:   Long timers are watched by helper counters
`timescale 1ns/1ps
module baler_press_cycle_controller_assertions
	import baler_pkg::*;
#(
	parameter logic [31:0] START_CYC = CYC_START,
	parameter logic [31:0] IDLE_CYC  = CYC_IDLE
)(
	input wire logic     pclk,
	input wire logic     presetn,
	input wire sensors_t sens,
	input wire keys_t    keys,
	input wire drive_t   drive,
	input wire leds_t    leds,
	input wire disp_t    display
);
	logic [31:0] idle_cnt;
	logic [31:0] on_cnt;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			idle_cnt <= '0;
			on_cnt   <= '0;
		end
		else
		begin
			idle_cnt <= (drive == 3'b100 && keys == 3'b000) ? idle_cnt + 1 : '0;
			on_cnt   <= drive.motor ? on_cnt + 1 : '0;
		end
	end
	property p_door_stop;
		!sens.door_shut && !keys.eject |=> !drive.motor;
	endproperty
	a_door_stop: assert property (p_door_stop) else $error("motor on, door open");
	property p_door_still;
		!sens.door_shut |=> !drive.up && !drive.down;
	endproperty
	a_door_still: assert property (p_door_still) else $error("fingers move, door open");
	property p_shut_eject;
		sens.door_shut && keys == 3'b001 && !drive.motor |=> !drive.motor;
	endproperty
	a_shut_eject: assert property (p_shut_eject) else $error("eject with door shut");
	property p_eject_stop;
		$fell(keys.eject) && !sens.door_shut |=> !drive.motor;
	endproperty
	a_eject_stop: assert property (p_eject_stop) else $error("motor after eject");
	property p_eject_leds;
		!sens.door_shut && keys.eject |-> ##[1:2] (leds.up && leds.down);
	endproperty
	a_eject_leds: assert property (p_eject_leds) else $error("eject leds off");
	property p_count_step;
		display.value != $past(display.value) |-> display.value == $past(display.value) + 16'h1;
	endproperty
	a_count_step: assert property (p_count_step) else $error("count step not one");
	property p_idle_off;
		idle_cnt <= IDLE_CYC + 4;
	endproperty
	a_idle_off: assert property (p_idle_off) else $error("idle motor not stopped");
	property p_spin_first;
		drive.up || drive.down |-> on_cnt + 2 >= START_CYC;
	endproperty
	a_spin_first: assert property (p_spin_first) else $error("stroke before spin-up");
	property p_ovr_step;
		$changed(display.code) && display.code inside {override_count_two, override_count_final}
			|-> $past(display.code) == display.code - 1;
	endproperty
	a_ovr_step: assert property (p_ovr_step) else $error("override code skipped");
	c_eject: cover property (keys.eject && drive.motor);
	c_final: cover property (display.code == override_count_final);
	c_down: cover property ($rose(drive.down));
endmodule : baler_press_cycle_controller_assertions

// ---- baler_hydraulic_model.sv ----
// Purpose: Pressure switch of the press, loaded at each stroke end
// Assumes: Fingers need TRAVEL cycles per stroke
// Notes:   fault 1 never closes, fault 2 jammed closed
`timescale 1ns/1ps
module baler_hydraulic_model
	import baler_pkg::*;
#(
	parameter int TRAVEL = 10
)(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire drive_t     drive,
	input  wire logic [1:0] fault,
	output logic            pressure
);
	int         travel_cnt;
	logic [1:0] last_dir;
	// A direction change restarts travel, so up-then-down unloads between strokes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			travel_cnt <= 0;
		else if ((drive.up || drive.down) && {drive.up, drive.down} == last_dir)
			travel_cnt <= travel_cnt + 1;
		else
			travel_cnt <= 0;
	end
	always_ff @(posedge pclk)
		last_dir <= {drive.up, drive.down};
	assign pressure = (fault == 2'h2) || (fault == 2'h0 && travel_cnt >= TRAVEL);
endmodule : baler_hydraulic_model

// ---- baler_press_cycle_controller_tb.sv ----
// Purpose: Self-checking bench of the press controller
// Assumes: Shortened timers, hydraulic model closes the loop
// Notes:   Keys are level holds released after a cycle count
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
	$display("mismatch %s expected %0h seen %0h", n, e, a); end end
`define WAIT_FOR(c) for (int w = 0; w < 400 && !(c); w++) @(posedge pclk)
module baler_press_cycle_controller_tb
	import baler_pkg::*;
;
	localparam logic [31:0] HOLD = 32'h8;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, rnd;
	logic        pready, pslverr, err, pressure;
	logic        door = 1'b1, hop = 1'b0, full = 1'b0, hot = 1'b0;
	logic [1:0]  guard = 2'h3;
	logic [1:0]  fault = 2'h0;
	keys_t       keys = '0;
	sensors_t    sens;
	drive_t      drive;
	leds_t       leds;
	disp_t       display;
	int          fail_count = 0;
	int          checks_done = 0;
	assign sens = {door, hop, full, pressure, hot, guard};
	baler_press_cycle_controller #(.HOLD_CYC(HOLD), .START_CYC(32'h14), .IDLE_CYC(32'h32),
		.SETTLE_CYC(32'h6), .STROKE_CYC(32'h64), .BLINK_CYC(32'h4)) uut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sens(sens),
		.keys(keys), .drive(drive), .leds(leds), .display(display));
	baler_hydraulic_model plant (.pclk(pclk), .presetn(presetn), .drive(drive),
		.fault(fault), .pressure(pressure));
	function automatic disp_code_t ovr_code(input int n);
		return (n == 1) ? override_count_one : (n == 2) ? override_count_two : override_count_final;
	endfunction : ovr_code
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic press(input keys_t k, input int n);
		keys <= k;
		repeat (n) @(posedge pclk);
		keys <= '0;
		@(posedge pclk);
	endtask : press
	task automatic report_and_stop;
		if (fail_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	initial
	begin
		forever #5 pclk = ~pclk;
	end
	initial
	begin
		repeat (60000) @(posedge pclk);
		fail_count++;
		report_and_stop();
	end
	initial
	begin
		void'($urandom(32'h14dd));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rnd = $urandom;
		apb(1'b1, ADDR_CTRL, rnd);
		apb(1'b0, ADDR_CTRL, 32'h0);
		`CHK("ctrl", {30'h0, rnd[1:0]}, rd)
		apb(1'b1, ADDR_COUNT, 32'hFFFF);
		apb(1'b0, ADDR_COUNT, 32'h0);
		`CHK("count ro", 32'h0, rd)
		apb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped", 1'b1, err)
		apb(1'b1, ADDR_CTRL, 32'h0);
		press(3'b010, 1 + $urandom % (HOLD - 3));
		`CHK("short hold", 1'b0, leds.up)
		press(3'b010, HOLD + 2);
		`CHK("up led", 2'b11, {leds.up, drive.motor})
		`WAIT_FOR(drive.up);
		`WAIT_FOR(!drive.up);
		`CHK("up led off", 1'b0, leds.up)
		`WAIT_FOR(!drive.motor);
		`CHK("idle stop", 1'b0, drive.motor)
		hop <= 1'b1;
		press(3'b100, HOLD + 2);
		`WAIT_FOR(drive.down);
		`CHK("down led", 1'b1, leds.down)
		`WAIT_FOR(leds.active);
		`CHK("active", 1'b1, leds.active)
		`WAIT_FOR(drive.up);
		`CHK("hopper raise", 1'b1, drive.up)
		hop <= 1'b0;
		`WAIT_FOR(drive.down);
		`CHK("lower again", 1'b1, drive.down)
		`WAIT_FOR(!drive.down);
		press(3'b010, HOLD + 2);
		apb(1'b0, ADDR_STATUS, 32'h0);
		`CHK("auto left", 1'b0, rd[3])
		`WAIT_FOR(!drive.up);
		full <= 1'b1;
		press(3'b100, HOLD + 2);
		`WAIT_FOR(drive.down);
		`CHK("full late", 1'b0, leds.full)
		`WAIT_FOR(!drive.down);
		repeat (2) @(posedge pclk);
		`CHK("full beeper", 2'b11, {leds.full, leds.beeper})
		for (int n = 1; n <= 4; n++)
		begin
			press(3'b100, HOLD + 2);
			`WAIT_FOR(drive.up || drive.down);
			`CHK("moved", n < 4, drive.up || drive.down)
			`WAIT_FOR(!drive.up && !drive.down);
			`CHK("override", ovr_code(n), display.code)
		end
		press(3'b010, HOLD + 2);
		`WAIT_FOR(drive.up);
		`CHK("retract final", 1'b1, drive.up)
		`WAIT_FOR(!drive.up);
		press(3'b100, HOLD + 2);
		`WAIT_FOR(drive.down);
		`CHK("no descent", 1'b0, drive.down)
		{door, full} <= 2'b00;
		press(3'b100, HOLD + 2);
		`CHK("door keys", 1'b0, leds.down | leds.up)
		keys <= 3'b001;
		repeat (4) @(posedge pclk);
		`CHK("eject", 3'b111, {drive.motor, leds.up, leds.down})
		keys <= '0;
		repeat (3) @(posedge pclk);
		`CHK("bales", 16'h1, display.value)
		`CHK("cleared", DISP_COUNT, display.code)
		door <= 1'b1;
		press(3'b001, 4);
		`CHK("shut eject", 1'b0, drive.motor)
		fault <= 2'h1;
		press(3'b100, HOLD + 2);
		`WAIT_FOR(display.code == DISP_PS_OPEN);
		`CHK("no close", DISP_PS_OPEN, display.code)
		fault <= 2'h2;
		// The first hold only clears the halt; a second one starts the stroke
		press(3'b010, HOLD + 2);
		press(3'b010, HOLD + 2);
		`WAIT_FOR(display.code == DISP_PS_JAM);
		`CHK("jammed", DISP_PS_JAM, display.code)
		fault <= 2'h0;
		press(3'b100, HOLD + 2);
		press(3'b100, HOLD + 2);
		`WAIT_FOR(drive.down);
		apb(1'b1, ADDR_CTRL, 32'h2);
		hot <= 1'b1;
		apb(1'b0, ADDR_STATUS, 32'h0);
		`CHK("hot", {DISP_HOT_OR_GUARD, 2'b00}, {display.code, display.guard, rd[3]})
		apb(1'b1, ADDR_CTRL, 32'h1);
		{hot, guard} <= 3'b010;
		press(3'b100, HOLD + 2);
		`CHK("guard", {DISP_HOT_OR_GUARD, 2'b10}, {display.code, display.guard, leds.down})
		apb(1'b1, ADDR_CTRL, 32'h0);
		{guard, hop} <= 3'b111;
		// A stuck hopper beam keeps auto cycling until the cycle limit trips
		press(3'b100, HOLD + 2);
		for (int i = 0; i < 20 && display.code != excess_cycling_code; i++)
			`WAIT_FOR(display.code == excess_cycling_code);
		`CHK("excess", excess_cycling_code, display.code)
		hop <= 1'b0;
		press(3'b100, HOLD + 2);
		`CHK("restart", DISP_COUNT, display.code)
		report_and_stop();
	end
endmodule : baler_press_cycle_controller_tb
bind baler_press_cycle_controller baler_press_cycle_controller_assertions #(
	.START_CYC(START_CYC),
	.IDLE_CYC (IDLE_CYC)
) chk (
	.pclk   (pclk),
	.presetn(presetn),
	.sens   (sens),
	.keys   (keys),
	.drive  (drive),
	.leds   (leds),
	.display(display)
);
